//--- design/fbs_status_words.sv
// Purpose: System, error and slave status words presented at each I/O refresh
// Assumes: refresh is a one-cycle pulse from same-clock logic; restart is srst
// Notes:   All outputs are registered; all but rd_data and mb_discard update only on refresh
`timescale 1ns/1ps
`include "fbs_defs.svh"

module fbs_status_words
#(
	parameter int NUM_SLAVE_WORDS = `FBS_NUM_SLAVE_WORDS
)
(
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  refresh,
	input  wire logic                  auto_clear_en,
	input  wire fbs_pkg::fbs_core_s    core,
	input  wire fbs_pkg::fbs_ctrl_s    ctrl,
	input  wire fbs_pkg::fbs_fault_s   fault,
	input  wire logic [15:0]           slave_in [NUM_SLAVE_WORDS],
	input  wire logic [2:0]            rd_addr,
	output fbs_pkg::fbs_word_t         rd_data,
	output fbs_pkg::fbs_word_t         sys_status,
	output fbs_pkg::fbs_word_t         err_status,
	output logic [15:0]                slave_status [NUM_SLAVE_WORDS],
	output logic                       comm_enable,
	output logic                       outputs_clear,
	output logic                       mb_discard
);
	import fbs_pkg::*;

	// ************************************************************
	// Mode and derived conditions
	// ************************************************************
	fbs_mode_e mode_q;
	fbs_mode_e mode_d;
	logic      fatal;
	logic      quiet;
	logic      size_err;
	logic [9:0] map_limit;

	always_comb
	begin
		map_limit = core.small_host ? `FBS_MAP_LIMIT_SMALL : `FBS_MAP_LIMIT_NORMAL;
		size_err  = core.map_words > map_limit;
		fatal     = core.hw_fail | core.wrong_host | size_err;
		quiet     = core.hw_fail | core.downloading;
	end

	// Auto-clear is sticky by design: only restart returns to run
	always_comb
	begin
		mode_d = mode_q;
		case (mode_q)
			FBS_ST_INIT:
				mode_d = FBS_ST_RUN;
			FBS_ST_RUN:
				if (refresh && auto_clear_en && core.remote_err && !quiet)
				begin
					mode_d = FBS_ST_AUTO;
				end
			FBS_ST_AUTO:
				mode_d = FBS_ST_AUTO;
			default:
				mode_d = FBS_ST_INIT;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			mode_q <= FBS_ST_INIT;
		else
			mode_q <= mode_d;
	end

	// ************************************************************
	// System status word
	// ************************************************************
	fbs_word_t  sys_d;
	fbs_word_t  err_d;
	logic [1:0] net;
	logic       comm_d;
	logic       oclr_d;
	logic       disc_d;

	always_comb
	begin
		if (quiet || fatal)
			net = `FBS_NET_OFFLINE;
		else if (mode_q == FBS_ST_AUTO)
			net = `FBS_NET_STOP;
		else if (core.net_run)
			net = `FBS_NET_OPERATE;
		else if (core.net_clear)
			net = `FBS_NET_CLEAR;
		else
			net = `FBS_NET_STOP;

		sys_d = 16'h0000;
		sys_d[`FBS_BIT_IN_XFER]      = core.in_fresh & ~ctrl.inhibit & ~fatal & ~quiet;
		sys_d[`FBS_BIT_AUTO_CLEAR]   = (mode_q == FBS_ST_AUTO) & ~quiet;
		sys_d[`FBS_BIT_NO_DATA]      = core.node_not_dx & ~quiet;
		sys_d[`FBS_BIT_HW_FAIL]      = core.hw_fail;
		sys_d[`FBS_BIT_WRONG_HOST]   = core.wrong_host;
		sys_d[`FBS_BIT_MAP_SIZE]     = size_err;
		sys_d[`FBS_BIT_OUT_MAP]      = core.out_map_bad;
		sys_d[`FBS_BIT_IN_MAP]       = core.in_map_bad;
		sys_d[`FBS_BIT_CMD_NOT_PROC] = ctrl.issue_cmd & (core.omb_full | ~ctrl.run | ctrl.inhibit);
		sys_d[`FBS_BIT_OMB_FULL]     = core.omb_full;
		sys_d[`FBS_BIT_REPLY_PEND]   = core.imb_reply;
		sys_d[`FBS_BIT_NET_HI:`FBS_BIT_NET_LO] = net;

		// Error word: type high byte, station low byte
		if (core.hw_fail || !fault.valid)
			err_d = 16'h0000;
		else if (fault.err_type == `FBS_ERR_NONE)
			err_d = 16'h0000;
		else
			err_d = {fault.err_type, fault.station};

		comm_d = ~fatal & ~quiet & (net != `FBS_NET_OFFLINE);
		oclr_d = (net == `FBS_NET_CLEAR) | (mode_q == FBS_ST_AUTO);
		disc_d = ctrl.mb_clear & core.imb_reply;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sys_status    <= 16'h0000;
			err_status    <= 16'h0000;
			comm_enable   <= 1'b0;
			outputs_clear <= 1'b1;
			mb_discard    <= 1'b0;
		end
		else
		begin
			mb_discard <= refresh & disc_d;
			if (refresh)
			begin
				sys_status    <= sys_d;
				err_status    <= err_d;
				comm_enable   <= comm_d;
				outputs_clear <= oclr_d;
			end
		end
	end

	// ************************************************************
	// Slave status words
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLAVE_WORDS; gi++)
		begin : g_slave
			logic [15:0] sl_d;
			always_comb
			begin
				sl_d = (quiet || fatal) ? 16'h0000 : slave_in[gi];
			end
			always_ff @(posedge clk)
			begin
				if (srst)
					slave_status[gi] <= 16'h0000;
				else if (refresh)
					slave_status[gi] <= sl_d;
			end
		end
	endgenerate

	// ************************************************************
	// Word read port
	// ************************************************************
	fbs_word_t rd_d;
	always_comb
	begin
		if (rd_addr == `FBS_OFS_SYS_STATUS)
			rd_d = sys_status;
		else if (rd_addr == `FBS_OFS_ERR_STATUS)
			rd_d = err_status;
		else
			rd_d = 16'h0000;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			rd_data <= 16'h0000;
		else
			rd_data <= rd_d;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	chk_offline_hw: assert property (@(posedge clk) disable iff (srst)
		$past(refresh) && $past(core.hw_fail) |-> sys_status[15:14] == 2'b00)
		else $error("network state not offline on hardware failure");
	chk_err_zero: assert property (@(posedge clk) disable iff (srst)
		$past(refresh) && $past(core.hw_fail) |-> err_status == 16'h0000)
		else $error("error word not zero on hardware failure");
	chk_slave_zero: assert property (@(posedge clk) disable iff (srst)
		$past(refresh) && $past(core.downloading) |-> slave_status[0] == 16'h0000)
		else $error("slave word not cleared during download");
	chk_auto_stop: assert property (@(posedge clk) disable iff (srst)
		$past(refresh) && $past(mode_q) == FBS_ST_AUTO && !$past(quiet) && !$past(fatal)
		|-> sys_status[15:14] == 2'b01)
		else $error("auto-clear does not report stop");
	chk_auto_sticky: assert property (@(posedge clk) disable iff (srst)
		mode_q == FBS_ST_AUTO |=> mode_q == FBS_ST_AUTO)
		else $error("auto-clear left without restart");
	chk_cmd_refused: assert property (@(posedge clk) disable iff (srst)
		refresh && ctrl.issue_cmd && !ctrl.run |=> sys_status[11])
		else $error("refused command not flagged");
	chk_map_size: assert property (@(posedge clk) disable iff (srst)
		refresh && core.small_host && core.map_words > 10'd80 |=> sys_status[8] && !comm_enable)
		else $error("mapping size error missed");
	chk_no_data: assert property (@(posedge clk) disable iff (srst)
		refresh && core.downloading |=> !sys_status[3] && !sys_status[2])
		else $error("status flag not cleared on download");
	chk_discard: assert property (@(posedge clk) disable iff (srst)
		mb_discard |-> $past(refresh) && $past(ctrl.mb_clear) && $past(core.imb_reply))
		else $error("discard without clear request");

	// ************************************************************
	// Flag, network state, error word, slave word, read and discard checks
	// ************************************************************
	chk_xfer_inhibit: assert property (@(posedge clk) disable iff (srst)
		refresh && ctrl.inhibit |=> !sys_status[0])
		else $error("input transferred while inhibited");
	chk_flags_quiet: assert property (@(posedge clk) disable iff (srst)
		refresh && core.hw_fail |=> !sys_status[2] && !sys_status[3])
		else $error("status flag not cleared on hardware failure");
	chk_hw_flag: assert property (@(posedge clk) disable iff (srst)
		refresh |=> sys_status[6] == $past(core.hw_fail))
		else $error("hardware failure flag wrong");
	chk_wrong_host: assert property (@(posedge clk) disable iff (srst)
		refresh && core.wrong_host |=> sys_status[7] && !comm_enable)
		else $error("wrong host not fatal");
	chk_map_normal: assert property (@(posedge clk) disable iff (srst)
		refresh && !core.small_host && core.map_words > 10'd300 |=> sys_status[8] && !comm_enable)
		else $error("normal mapping size error missed");
	chk_out_map: assert property (@(posedge clk) disable iff (srst)
		refresh |=> sys_status[9] == $past(core.out_map_bad))
		else $error("output mapping flag wrong");
	chk_in_map: assert property (@(posedge clk) disable iff (srst)
		refresh |=> sys_status[10] == $past(core.in_map_bad))
		else $error("input mapping flag wrong");
	chk_cmd_taken: assert property (@(posedge clk) disable iff (srst)
		refresh && ctrl.issue_cmd && ctrl.run && !ctrl.inhibit && !core.omb_full |=> !sys_status[11])
		else $error("accepted command flagged as refused");
	chk_omb_full: assert property (@(posedge clk) disable iff (srst)
		refresh |=> sys_status[12] == $past(core.omb_full))
		else $error("mailbox full flag wrong");
	chk_reply_pend: assert property (@(posedge clk) disable iff (srst)
		refresh |=> sys_status[13] == $past(core.imb_reply))
		else $error("reply pending flag wrong");
	chk_clear_state: assert property (@(posedge clk) disable iff (srst)
		sys_status[15:14] == 2'b10 |-> outputs_clear)
		else $error("outputs not cleared in clear state");
	chk_offline_dl: assert property (@(posedge clk) disable iff (srst)
		refresh && core.downloading |=> sys_status[15:14] == 2'b00)
		else $error("network state not offline during download");
	chk_slave_fatal: assert property (@(posedge clk) disable iff (srst)
		refresh && core.hw_fail |=> slave_status[NUM_SLAVE_WORDS-1] == 16'h0000)
		else $error("slave word not cleared on hardware failure");
	chk_err_fields: assert property (@(posedge clk) disable iff (srst)
		refresh && fault.valid && !core.hw_fail && fault.err_type != 8'h00
		|=> err_status[15:8] == $past(fault.err_type) && err_status[7:0] == $past(fault.station))
		else $error("error word fields wrong");
	chk_err_none: assert property (@(posedge clk) disable iff (srst)
		refresh && fault.err_type == 8'h00 |=> err_status == 16'h0000)
		else $error("error word not zero without error");
	chk_status_hold: assert property (@(posedge clk) disable iff (srst)
		!refresh |=> $stable(sys_status))
		else $error("system status changed between refreshes");
	chk_rd_sys: assert property (@(posedge clk) disable iff (srst)
		rd_addr == 3'h2 |=> rd_data == $past(sys_status))
		else $error("system status read wrong");
	chk_discard_req: assert property (@(posedge clk) disable iff (srst)
		refresh && ctrl.mb_clear && core.imb_reply |=> mb_discard)
		else $error("requested discard missing");

endmodule

//--- common/fbs_defs.svh
// Purpose: Offsets, field positions, codes and limits of the fieldbus status words
// Assumes: Word offsets are relative to the unit's first control word
// Notes:   Included by the package and the design
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ************************************************************
// Word offsets
// ************************************************************
`define FBS_OFS_SYS_STATUS      3'h2
`define FBS_OFS_ERR_STATUS      3'h3
`define FBS_NUM_STATUS_WORDS    19
`define FBS_NUM_SLAVE_WORDS     16

// ************************************************************
// System status bit positions
// ************************************************************
`define FBS_BIT_IN_XFER         0
`define FBS_BIT_AUTO_CLEAR      2
`define FBS_BIT_NO_DATA         3
`define FBS_BIT_HW_FAIL         6
`define FBS_BIT_WRONG_HOST      7
`define FBS_BIT_MAP_SIZE        8
`define FBS_BIT_OUT_MAP         9
`define FBS_BIT_IN_MAP          10
`define FBS_BIT_CMD_NOT_PROC    11
`define FBS_BIT_OMB_FULL        12
`define FBS_BIT_REPLY_PEND      13
`define FBS_BIT_NET_LO          14
`define FBS_BIT_NET_HI          15

// ************************************************************
// Network state codes
// ************************************************************
`define FBS_NET_OFFLINE         2'h0
`define FBS_NET_STOP            2'h1
`define FBS_NET_CLEAR           2'h2
`define FBS_NET_OPERATE         2'h3

// ************************************************************
// Error types and station address
// ************************************************************
`define FBS_ERR_NONE            8'h00
`define FBS_ERR_NOT_ACTIVATED   8'h03
`define FBS_ERR_NO_RESPONSE     8'h11
`define FBS_ERR_NOT_IN_RING     8'h12
`define FBS_ERR_CFG_A           8'h36
`define FBS_ERR_CFG_B           8'h38
`define FBS_ERR_CFG_C           8'hD4
`define FBS_ERR_BUS             8'hBE
`define FBS_STATION_MASTER      8'hFF

// ************************************************************
// Mapping limits in words
// ************************************************************
`define FBS_MAP_LIMIT_NORMAL    10'd300
`define FBS_MAP_LIMIT_SMALL     10'd80

`endif

//--- common/fbs_pkg.sv
// Purpose: Types shared by the fieldbus status block
// Assumes: fbs_defs.svh holds the numeric constants
// Notes:   Structs carry grouped inputs from the master core, the host control words and the station scanner
`include "fbs_defs.svh"

package fbs_pkg;

	typedef logic [15:0] fbs_word_t;

	// Events and conditions reported by the master core at each refresh
	typedef struct packed
	{
		logic       in_fresh;
		logic       remote_err;
		logic       node_not_dx;
		logic       hw_fail;
		logic       wrong_host;
		logic       small_host;
		logic [9:0] map_words;
		logic       out_map_bad;
		logic       in_map_bad;
		logic       downloading;
		logic       omb_full;
		logic       imb_reply;
		logic       net_run;
		logic       net_clear;
	} fbs_core_s;

	// Control bits from the host control words
	typedef struct packed
	{
		logic run;
		logic inhibit;
		logic mb_clear;
		logic issue_cmd;
	} fbs_ctrl_s;

	// Fault report from the station scanner
	typedef struct packed
	{
		logic       valid;
		logic [7:0] err_type;
		logic [7:0] station;
	} fbs_fault_s;

	typedef enum logic [2:0]
	{
		FBS_ST_INIT = 3'b001,
		FBS_ST_RUN  = 3'b010,
		FBS_ST_AUTO = 3'b100
	} fbs_mode_e;

endpackage

//--- test/fbs_host_model.sv
// Purpose: Host CPU side of the status block: refresh pulses, control bits, reads
// Assumes: Called by the bench; drives only on the falling edge
// Notes:   Control bits stay as levels between refreshes, as a control word would
`timescale 1ns/1ps

module fbs_host_model
(
	input  wire logic               clk,
	output logic                    refresh,
	output fbs_pkg::fbs_ctrl_s      ctrl,
	output logic [2:0]              rd_addr,
	input  wire fbs_pkg::fbs_word_t rd_data
);
	import fbs_pkg::*;

	// ************************************************************
	// Host accesses
	// ************************************************************
	initial
	begin
		refresh = 1'b0;
		ctrl = '0;
		rd_addr = 3'h0;
	end

	// One refresh; the words are settled when this returns
	task automatic io_refresh(input fbs_ctrl_s c);
		@(negedge clk);
		ctrl = c;
		refresh = 1'b1;
		@(negedge clk);
		refresh = 1'b0;
	endtask

	// The word is read in the cycle that follows setting the address
	task automatic read_word(input logic [2:0] a, output fbs_word_t d);
		@(negedge clk);
		rd_addr = a;
		@(negedge clk);
		d = rd_data;
	endtask
endmodule

//--- test/fbs_status_words_tb.sv
// Purpose: Self-checking bench for the status word block
// Assumes: Host model makes refreshes; bench sets core, fault and slave inputs
// Notes:   All inputs change on the falling edge
`timescale 1ns/1ps

module fbs_status_words_tb;
	import fbs_pkg::*;

	// ************************************************************
	// Bench
	// ************************************************************
	logic        clk, srst, refresh, auto_clear_en, comm_enable, outputs_clear, mb_discard;
	fbs_core_s   core, k;
	fbs_ctrl_s   ctrl, c;
	fbs_fault_s  fault;
	logic [15:0] slave_in [16];
	logic [15:0] slave_status [16];
	logic [2:0]  rd_addr;
	fbs_word_t   rd_data, sys_status, err_status, w;
	logic [7:0]  ty [7] = '{8'h03, 8'h11, 8'h12, 8'h36, 8'h38, 8'hD4, 8'hBE};
	int          n_errors, check_count;

	fbs_status_words DUT (.clk(clk), .srst(srst), .refresh(refresh), .auto_clear_en(auto_clear_en),
		.core(core), .ctrl(ctrl), .fault(fault), .slave_in(slave_in), .rd_addr(rd_addr), .rd_data(rd_data),
		.sys_status(sys_status), .err_status(err_status), .slave_status(slave_status),
		.comm_enable(comm_enable), .outputs_clear(outputs_clear), .mb_discard(mb_discard));
	fbs_host_model host (.clk(clk), .refresh(refresh), .ctrl(ctrl), .rd_addr(rd_addr), .rd_data(rd_data));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic run(input fbs_core_s kk, input fbs_ctrl_s cc);
		core = kk;
		host.io_refresh(cc);
	endtask

	task automatic chk_slaves(input logic zero);
		for (int i = 0; i < 16; i++)
			chk("slave_status", zero ? 16'h0000 : slave_in[i], slave_status[i]);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// A hang is cut short here
	initial
	begin
		#1000000;
		n_errors++;
		results();
	end

	initial
	begin
		srst = 1'b1;
		auto_clear_en = 1'b0;
		core = '0;
		fault = '0;
		for (int i = 0; i < 16; i++)
			slave_in[i] = 16'hA500 + 16'(i);
		repeat (20) @(negedge clk);
		chk("sys_status", 16'h0000, sys_status);
		chk("outputs_clear", 16'h0001, {15'h0, outputs_clear});
		srst = 1'b0;
		@(negedge clk);
		k = '0;
		k.net_run = 1'b1;
		k.in_fresh = 1'b1;
		run(k, '0);
		chk("sys_status", 16'hC001, sys_status);
		chk("comm_enable", 16'h0001, {15'h0, comm_enable});
		chk_slaves(1'b0);
		c = '0;
		c.inhibit = 1'b1;
		run(k, c);
		chk("sys_status", 16'hC000, sys_status);
		k.in_fresh = 1'b0;
		run(k, '0);
		chk("sys_status", 16'hC000, sys_status);
		$display("test operate done");
		k = '{net_run:1'b1, omb_full:1'b1, imb_reply:1'b1, out_map_bad:1'b1, in_map_bad:1'b1, node_not_dx:1'b1, default:'0};
		c = '0;
		c.mb_clear = 1'b1;
		run(k, c);
		chk("sys_status", 16'hF608, sys_status);
		chk("mb_discard", 16'h0001, {15'h0, mb_discard});
		k = '0;
		k.net_run = 1'b1;
		run(k, c);
		chk("mb_discard", 16'h0000, {15'h0, mb_discard});
		c = '0;
		c.issue_cmd = 1'b1;
		run(k, c);
		chk("sys_status", 16'hC800, sys_status);
		c.run = 1'b1;
		run(k, c);
		chk("sys_status", 16'hC000, sys_status);
		k.omb_full = 1'b1;
		run(k, c);
		chk("sys_status", 16'hD800, sys_status);
		$display("test flags done");
		k = '0;
		k.net_clear = 1'b1;
		run(k, '0);
		chk("sys_status", 16'h8000, sys_status);
		chk("outputs_clear", 16'h0001, {15'h0, outputs_clear});
		k.net_clear = 1'b0;
		run(k, '0);
		chk("sys_status", 16'h4000, sys_status);
		for (int i = 0; i < 7; i++)
		begin
			fault = '{1'b1, ty[i], (i > 2) ? 8'hFF : 8'h05};
			run(k, '0);
			chk("err_status", {ty[i], (i > 2) ? 8'hFF : 8'h05}, err_status);
		end
		host.read_word(3'h3, w);
		chk("rd_data", 16'hBEFF, w);
		host.read_word(3'h2, w);
		chk("rd_data", 16'h4000, w);
		host.read_word(3'h6, w);
		chk("rd_data", 16'h0000, w);
		k = '0;
		k.net_run = 1'b1;
		k.hw_fail = 1'b1;
		run(k, '0);
		chk("sys_status", 16'h0040, sys_status);
		chk("err_status", 16'h0000, err_status);
		chk("comm_enable", 16'h0000, {15'h0, comm_enable});
		chk_slaves(1'b1);
		k.hw_fail = 1'b0;
		fault = '{1'b1, 8'h00, 8'h07};
		run(k, '0);
		chk("err_status", 16'h0000, err_status);
		$display("test errors done");
		fault = '0;
		for (int i = 0; i < 4; i++)
		begin
			k = '0;
			k.net_run = 1'b1;
			k.small_host = i[1];
			k.map_words = (i[1] ? 10'd80 : 10'd300) + 10'(i[0]);
			run(k, '0);
			chk("sys_status", i[0] ? 16'h0100 : 16'hC000, sys_status);
		end
		k = '0;
		k.net_run = 1'b1;
		k.wrong_host = 1'b1;
		run(k, '0);
		chk("sys_status", 16'h0080, sys_status);
		chk("comm_enable", 16'h0000, {15'h0, comm_enable});
		k = '{net_run:1'b1, downloading:1'b1, node_not_dx:1'b1, default:'0};
		run(k, '0);
		chk("sys_status", 16'h0000, sys_status);
		chk_slaves(1'b1);
		$display("test fatal done");
		auto_clear_en = 1'b1;
		k = '0;
		k.net_run = 1'b1;
		k.remote_err = 1'b1;
		run(k, '0);
		// Mode is entered at this refresh and reported from the next one
		chk("sys_status", 16'hC000, sys_status);
		k.remote_err = 1'b0;
		run(k, '0);
		chk("sys_status", 16'h4004, sys_status);
		chk("outputs_clear", 16'h0001, {15'h0, outputs_clear});
		run(k, '0);
		chk("sys_status", 16'h4004, sys_status);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk("sys_status", 16'h0000, sys_status);
		run(k, '0);
		chk("sys_status", 16'hC000, sys_status);
		auto_clear_en = 1'b0;
		k.remote_err = 1'b1;
		run(k, '0);
		chk("sys_status", 16'hC000, sys_status);
		run(k, '0);
		chk("sys_status", 16'hC000, sys_status);
		$display("test auto clear done");
		results();
	end
endmodule
